//--- verilog/nel_pkg.sv
/*
 * Constants and types shared by the nibble expander link:
 * operation and port-select codes, nibble field positions and strobe
 * phase timing.
 * Assumes a single 40 MHz ref_clk. Phase times are minimum figures,
 * so each one is rounded up to whole clock cycles.
 */
package nel_pkg;

    localparam int NIB_W = 4;
    localparam int ACC_W = 8;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_OR = 2'h2,
        OP_AND = 2'h3
    } nel_op_e;

    typedef enum logic [1:0] {
        SEL_PORT4 = 2'h0,
        SEL_PORT5 = 2'h1,
        SEL_PORT6 = 2'h2,
        SEL_PORT7 = 2'h3
    } nel_port_e;

    // command nibble layout: op code high, port select low
    localparam int OPCODE_LSB = 2;
    localparam int PORTSEL_LSB = 0;

    // reset values of the link pins
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [3:0] NIB_RESET = 4'h0;

    localparam int CLK_PERIOD_NS = 25;
    localparam int SEL_SETUP_NS = 50;
    localparam int CMD_HOLD_NS = 80;
    localparam int DATA_LOW_NS = 150;
    localparam int TAIL_NS = 60;

    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] SEL_SETUP_CYC =
        TMR_W'((SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] CMD_HOLD_CYC =
        TMR_W'((CMD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] DATA_LOW_CYC =
        TMR_W'((DATA_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TAIL_CYC =
        TMR_W'((TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : nel_pkg

//--- verilog/nel_timer.sv
/*
 * Down-counting phase timer for the nibble expander link.
 * Assumes the owner loads a non-zero count in the cycle a phase begins
 * and waits for expired; a load wins over counting.
 */
module nel_timer #(
    parameter int W = 4
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic load, // start a new phase
    input wire logic [W-1:0] loadVal, // phase length in cycles
    output logic expired // count has run out
);
    typedef struct packed {
        logic [W-1:0] count;
    } nel_tmr_s;

    nel_tmr_s st_q;
    nel_tmr_s st_d;

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.count = loadVal;
        end else if (st_q.count != '0) begin
            st_d.count = st_q.count - W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired = (st_q.count == '0);

endmodule : nel_timer

//--- verilog/nel_link.sv
/*
 * Processor end of the four-line nibble expander link.
 * A request names an expander, a port (four to seven), an operation and
 * a data nibble; the block sends the command nibble, then the data nibble
 * or takes the read nibble, framing both with the strobe.
 * Every transfer takes the same number of clocks whatever the operation,
 * since one down-counter times all four phases; a read only leaves the
 * lines released through the data and tail phases.
 * Assumes expanders sample on the strobe edges, that pin inputs are
 * synchronous to ref_clk and that the board resolves the shared lines.
 */
module nel_link
#(
    parameter int NUM_EXP = 1
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic reqValid, // request offered
    input wire nel_pkg::nel_op_e reqOp, // operation
    input wire nel_pkg::nel_port_e reqPort, // expander port select
    input wire logic [$clog2(NUM_EXP+1)-1:0] reqExp, // expander index
    input wire logic [nel_pkg::NIB_W-1:0] reqData, // accumulator low nibble
    output logic reqReady, // idle, request may be taken
    output logic done, // one-cycle pulse at end of transfer
    output logic [nel_pkg::ACC_W-1:0] rdAcc, // read result to accumulator
    output logic expanderStrobe, // transfer strobe, idles high
    output logic [nel_pkg::NIB_W-1:0] port2LowNibbleOut, // link lines out
    output logic [nel_pkg::NIB_W-1:0] port2LowNibbleOe, // high while driving
    input wire logic [nel_pkg::NIB_W-1:0] port2LowNibbleIn, // link lines in
    output logic [NUM_EXP-1:0] expSelN // expander chip selects, low
);
    import nel_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_CMD,
        ST_DATA,
        ST_TAIL
    } nel_state_e;

    typedef struct packed {
        nel_state_e state;
        logic isRead;
        logic [NIB_W-1:0] dataNib;
        logic ready;
        logic done;
        logic [ACC_W-1:0] acc;
        logic strobe;
        logic [NIB_W-1:0] lineOut;
        logic [NIB_W-1:0] lineOe;
        logic [NUM_EXP-1:0] selN;
    } nel_link_s;

    nel_link_s st_q;
    nel_link_s st_d;

    logic tmrLoad;
    logic [TMR_W-1:0] tmrVal;
    logic tmrExpired;

    nel_timer #(
        .W(TMR_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(tmrLoad),
        .loadVal(tmrVal),
        .expired(tmrExpired)
    );

    // active-low select for the addressed expander; all high if no index matches
    function automatic logic [NUM_EXP-1:0] selDecode(
        input logic [$clog2(NUM_EXP+1)-1:0] idx
    );
        logic [NUM_EXP-1:0] sel;
        sel = '1;
        for (int i = 0; i < NUM_EXP; i++) begin
            if (idx == ($clog2(NUM_EXP+1))'(i)) begin
                sel[i] = 1'b0;
            end
        end
        return sel;
    endfunction : selDecode

    // command nibble: op code in the high pair, port select in the low pair
    function automatic logic [NIB_W-1:0] cmdNibble(
        input nel_op_e op,
        input nel_port_e port
    );
        logic [NIB_W-1:0] nib;
        nib = NIB_RESET;
        nib[OPCODE_LSB +: 2] = op;
        nib[PORTSEL_LSB +: 2] = port;
        return nib;
    endfunction : cmdNibble

    // timer load for the phase that a state begins
    function automatic logic [TMR_W-1:0] phaseLen(
        input nel_state_e s
    );
        logic [TMR_W-1:0] n;
        case (s)
            ST_SETUP: n = SEL_SETUP_CYC;
            ST_CMD: n = CMD_HOLD_CYC;
            ST_DATA: n = DATA_LOW_CYC;
            ST_TAIL: n = TAIL_CYC;
            default: n = SEL_SETUP_CYC;
        endcase
        return n;
    endfunction : phaseLen

    // link pins at their idle levels: strobe high, lines free, no select
    function automatic nel_link_s releaseLink(
        input nel_link_s s
    );
        nel_link_s r;
        r = s;
        r.strobe = STROBE_IDLE;
        r.selN = '1;
        r.lineOe = '0;
        r.lineOut = NIB_RESET;
        r.ready = 1'b1;
        return r;
    endfunction : releaseLink

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        tmrLoad = 1'b0;
        tmrVal = SEL_SETUP_CYC;
        case (st_q.state)
            ST_IDLE: begin
                if (reqValid) begin
                    // select the addressed expander, if any, drive command, strobe high
                    st_d.state = ST_SETUP;
                    st_d.ready = 1'b0;
                    st_d.isRead = (reqOp == OP_READ);
                    st_d.dataNib = reqData;
                    st_d.selN = selDecode(reqExp);
                    st_d.lineOut = cmdNibble(reqOp, reqPort);
                    st_d.lineOe = '1;
                    st_d.strobe = 1'b1;
                    tmrLoad = 1'b1;
                    tmrVal = phaseLen(ST_SETUP);
                end
            end
            ST_SETUP: begin
                if (tmrExpired) begin
                    // falling edge: command nibble is valid
                    st_d.state = ST_CMD;
                    st_d.strobe = 1'b0;
                    tmrLoad = 1'b1;
                    tmrVal = phaseLen(ST_CMD);
                end
            end
            ST_CMD: begin
                if (tmrExpired) begin
                    st_d.state = ST_DATA;
                    if (st_q.isRead) begin
                        // hand the lines to the expander
                        st_d.lineOe = '0;
                        st_d.lineOut = NIB_RESET;
                    end else begin
                        st_d.lineOut = st_q.dataNib;
                    end
                    tmrLoad = 1'b1;
                    tmrVal = phaseLen(ST_DATA);
                end
            end
            ST_DATA: begin
                if (tmrExpired) begin
                    // rising edge: data nibble is valid
                    st_d.state = ST_TAIL;
                    st_d.strobe = 1'b1;
                    if (st_q.isRead) begin
                        // sampled while the strobe is still low
                        st_d.acc = {4'h0, port2LowNibbleIn};
                    end
                    tmrLoad = 1'b1;
                    tmrVal = phaseLen(ST_TAIL);
                end
            end
            ST_TAIL: begin
                if (tmrExpired) begin
                    // hold data past the rise, then drop select and lines
                    st_d = releaseLink(st_d);
                    st_d.state = ST_IDLE;
                    st_d.done = 1'b1;
                end
            end
            default: begin
                st_d = releaseLink(st_d);
                st_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.state <= ST_IDLE;
            st_q.isRead <= 1'b0;
            st_q.dataNib <= NIB_RESET;
            st_q.ready <= 1'b1;
            st_q.done <= 1'b0;
            st_q.acc <= 8'h00;
            st_q.strobe <= STROBE_IDLE;
            st_q.lineOut <= NIB_RESET;
            st_q.lineOe <= '0;
            st_q.selN <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    // every output is a field of the registered state
    assign reqReady = st_q.ready;
    assign done = st_q.done;
    assign rdAcc = st_q.acc;
    assign expanderStrobe = st_q.strobe;
    assign port2LowNibbleOut = st_q.lineOut;
    assign port2LowNibbleOe = st_q.lineOe;
    assign expSelN = st_q.selN;

endmodule : nel_link

//--- dv/nel_monitor.sv
/* Checker for nel_link: request and link timing.
   Sees only the link ports; bound below. */
module nel_monitor
    import nel_pkg::*;
#(
    parameter int NUM_EXP = 1
) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    input wire logic reqValid, // request
    input wire nel_pkg::nel_op_e reqOp, // op
    input wire nel_pkg::nel_port_e reqPort, // port
    input wire logic [$clog2(NUM_EXP+1)-1:0] reqExp, // expander
    input wire logic [nel_pkg::NIB_W-1:0] reqData, // data
    input wire logic reqReady, // idle
    input wire logic done, // end pulse
    input wire logic [nel_pkg::ACC_W-1:0] rdAcc, // read result
    input wire logic expanderStrobe, // strobe
    input wire logic [nel_pkg::NIB_W-1:0] port2LowNibbleOut, // lines out
    input wire logic [nel_pkg::NIB_W-1:0] port2LowNibbleOe, // drive
    input wire logic [nel_pkg::NIB_W-1:0] port2LowNibbleIn, // lines in
    input wire logic [NUM_EXP-1:0] expSelN // selects
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    nel_op_e op_q;
    nel_port_e port_q;
    logic [$clog2(NUM_EXP+1)-1:0] exp_q;
    logic [NIB_W-1:0] data_q;
    always_ff @(posedge ref_clk) begin
        if (reqValid && reqReady) begin
            op_q <= reqOp;
            port_q <= reqPort;
            exp_q <= reqExp;
            data_q <= reqData;
        end
    end
    sequence s_take;
        reqValid && reqReady;
    endsequence
    sequence s_low;
        !expanderStrobe [*8];
    endsequence
    a_take_busy: assert property (s_take |=> !reqReady)
        else $error("still ready after take");
    a_done_bound: assert property (s_take |-> ##20 done)
        else $error("no done after request");
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    a_idle_free: assert property (reqReady |-> expanderStrobe &&
        port2LowNibbleOe == 4'h0 && &expSelN) else $error("idle not free");
    a_cmd_fall: assert property ($fell(expanderStrobe) |->
        port2LowNibbleOe == 4'hF && port2LowNibbleOut == {op_q, port_q})
        else $error("bad command nibble");
    a_strobe_low: assert property ($fell(expanderStrobe) |-> s_low)
        else $error("strobe pulse short");
    a_write_data: assert property ($rose(expanderStrobe) &&
        op_q != OP_READ |-> port2LowNibbleOut == data_q &&
        port2LowNibbleOe == 4'hF) else $error("bad data nibble");
    a_read_take: assert property ($rose(expanderStrobe) &&
        op_q == OP_READ |-> port2LowNibbleOe == 4'h0 &&
        rdAcc == {4'h0, $past(port2LowNibbleIn)}) else $error("bad read");
    a_select_one: assert property (!expanderStrobe |->
        expSelN == ~(NUM_EXP'(1) << exp_q)) else $error("bad select");
endmodule : nel_monitor

bind nel_link nel_monitor #(.NUM_EXP(NUM_EXP)) mon (.ref_clk(ref_clk),
    .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp), .reqPort(reqPort),
    .reqExp(reqExp), .reqData(reqData), .reqReady(reqReady), .done(done),
    .rdAcc(rdAcc), .expanderStrobe(expanderStrobe),
    .port2LowNibbleOut(port2LowNibbleOut), .expSelN(expSelN),
    .port2LowNibbleOe(port2LowNibbleOe), .port2LowNibbleIn(port2LowNibbleIn));

//--- dv/nel_expander_model.sv
/* Expander model: four nibble ports behind the strobe link.
   Expects resolved lines from the bench, ref_clk for read lag. */
module nel_expander_model
    import nel_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic [3:0] readLag, // cycles after fall before driving
    input wire logic strobe, // link strobe
    input wire logic selN, // chip select, low
    input wire logic [3:0] lines, // resolved lines
    output logic [3:0] drvVal, // read nibble
    output logic drvEn // high while driving
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] port [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    logic [1:0] op = 2'h1;
    logic [1:0] sel = 2'h0;
    logic [3:0] cnt = 4'h0;
    always @(negedge strobe) begin
        if (!selN) begin
            op = lines[3:2];
            sel = lines[1:0];
        end
    end
    always @(posedge strobe) begin
        if (!selN && op != OP_READ) begin
            port[sel] = op == OP_WRITE ? lines : op == OP_OR ?
                port[sel] | lines : port[sel] & lines;
        end
    end
    always @(posedge ref_clk) begin
        cnt <= (!selN && !strobe && op == OP_READ) ? cnt + 4'h1 : 4'h0;
    end
    assign drvEn = !selN && !strobe && op == OP_READ && cnt >= readLag;
    assign drvVal = port[sel];
endmodule : nel_expander_model

//--- dv/nel_link_bench.sv
/* Bench for nel_link with expander model and bound checker.
   Makes its own 40 MHz clock and reset. */
module nel_link_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nel_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    nel_op_e reqOp = OP_READ;
    nel_port_e reqPort = SEL_PORT4;
    logic [0:0] reqExp = 1'b0;
    logic [3:0] reqData = 4'h0;
    logic [3:0] readLag = 4'h6;
    logic [3:0] float_q = 4'h0;
    logic reqReady, done, expanderStrobe, drvEn;
    logic [7:0] rdAcc;
    logic [3:0] lineOut, lineOe, lineIn, drvVal;
    logic [0:0] expSelN;
    int nErrors = 0;
    int checkCount = 0;
    // released lines wander so a late drive cannot pass by luck
    assign lineIn = lineOe[0] ? lineOut : drvEn ? drvVal : float_q;
    nel_link #(.NUM_EXP(1)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reqValid(reqValid), .reqOp(reqOp), .reqPort(reqPort),
        .reqExp(reqExp), .reqData(reqData), .reqReady(reqReady),
        .done(done), .rdAcc(rdAcc), .expanderStrobe(expanderStrobe),
        .port2LowNibbleOut(lineOut), .port2LowNibbleOe(lineOe),
        .port2LowNibbleIn(lineIn), .expSelN(expSelN));
    nel_expander_model peer (.ref_clk(ref_clk), .readLag(readLag),
        .strobe(expanderStrobe), .selN(expSelN[0]), .lines(lineIn),
        .drvVal(drvVal), .drvEn(drvEn));
    always @(posedge ref_clk) float_q <= float_q + 4'h7;
    task automatic xfer(input nel_op_e op, input nel_port_e p,
            input logic ex, input logic [3:0] d);
        int i;
        int cyc;
        // each phase lasts its count plus its load edge; done seen one later
        cyc = int'(SEL_SETUP_CYC) + int'(CMD_HOLD_CYC) + int'(DATA_LOW_CYC)
            + int'(TAIL_CYC) + 5;
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqPort <= p;
        reqExp <= ex;
        reqData <= d;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge ref_clk);
        checkCount++;
        if (done !== 1'b1 || i != cyc) begin
            nErrors++;
            $display("mismatch done cycle expected %0d seen %0d", cyc, i);
        end
    endtask : xfer
    task automatic rd(input nel_port_e p, input logic [3:0] e);
        xfer(OP_READ, p, 1'b0, 4'h0);
        checkCount++;
        if (rdAcc !== {4'h0, e}) begin
            nErrors++;
            $display("mismatch rdAcc expected %h seen %h", {4'h0, e}, rdAcc);
        end
    endtask : rd
    task automatic t_ports;
        for (int i = 0; i < 4; i++) xfer(OP_WRITE, nel_port_e'(i), 1'b0, 4'(i + 9));
        for (int i = 0; i < 4; i++) rd(nel_port_e'(i), 4'(i + 9));
    endtask : t_ports
    task automatic t_logic;
        readLag <= 4'h9;
        xfer(OP_WRITE, SEL_PORT5, 1'b0, 4'h5);
        xfer(OP_OR, SEL_PORT5, 1'b0, 4'h6);
        rd(SEL_PORT5, 4'h7);
        xfer(OP_AND, SEL_PORT5, 1'b0, 4'hC);
        rd(SEL_PORT5, 4'h4);
    endtask : t_logic
    task automatic t_select;
        xfer(OP_WRITE, SEL_PORT6, 1'b1, 4'h0);
        rd(SEL_PORT6, 4'hB);
    endtask : t_select
    task automatic finishTest;
        if (nErrors == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finishTest
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_ports();
        t_logic();
        t_select();
        finishTest();
    end
    initial begin
        #60000;
        nErrors++;
        finishTest();
    end
endmodule : nel_link_bench
